/* design/adc_host_if.sv */
//
// Summary of operation
// RULE1: busy rises after a rising edge on any pair start input.
// RULE2: busy falls once the last converting pair's result is in its register.
// RULE3: host may read results right after busy falls.
// RULE4: sequential mode drops busy for one cycle when a pair finishes.
// RULE5: interrupt mode raises the output at completion; reads do not clear it.
// RULE6: control bit 20 inverts busy/interrupt polarity.
// RULE7: control bit 18 selects 2.5 V or 3 V reference range.
// RULE8: reference DAC code comes from control bits 9..0.
// RULE9: host should keep the DAC code at or above 0.5 V.
// RULE10: after reset the internal reference is powered down.
// RULE11: source select 0 uses own starts; 1 uses pair A start for all. The code keeps own starts with select 1 in sequential mode.
// RULE12: pin mode allows only bits 22:18, 15:13, 9:0; serial ignores top byte.
// RULE13: register mode uses the whole word; serial host sends a word each access. Serial register-mode writes keep bits 23:0 unless bit 16 is set.
// RULE14: interface select low gives parallel port, 16 or 8 bits wide.
// RULE15: byte mode order on the upper byte lanes follows byte order select.
// RULE16: serial transfer starts on the falling edge of frame strobe.
// RULE17: results go out MSB first, changing on rising serial clock.
// RULE18: serial input bits are captured on falling serial clock.
// RULE19: three lanes each send first then second channel of their pair.
// RULE20: two lanes: A sends A0 A1 C0, B sends B0 B1 C1.
// RULE21: one lane sends A0 A1 B0 B1 C0 C1.
// RULE22: results are two's complement.
// RULE23: a pair's inputs are held at its start edge; conversion follows.
// RULE24: sequential mode needs both external clock select and sequential enable.
// RULE25: disabled serial lanes stay low during a transfer.
//
`timescale 1ns/1ps
module adc_host_if
	import adc_if_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [2:0]  pair_sample_start_in,
	input  wire logic        config_source_select_in,
	input  wire logic        interface_select_in,
	input  wire logic        word_byte_select_in,
	input  wire logic        byte_order_select_in,
	input  wire logic        chip_select_b_in,
	input  wire logic        read_strobe_b_in,
	input  wire logic        frame_strobe_in,
	input  wire logic        serial_clk_in,
	input  wire logic        serial_data_in,
	input  wire logic [2:0]  lane_enable_in,
	input  wire logic [47:0] pair_first_input_in,
	input  wire logic [47:0] pair_second_input_in,
	input  wire logic        cfg_write_in,
	input  wire logic [31:0] cfg_word_in,
	output logic             busy_int_out,
	output logic [15:0]      parallel_data_bus_out,
	output logic             parallel_data_oe_b_out,
	output logic             serial_out_lane_a_out,
	output logic             serial_out_lane_b_out,
	output logic             serial_out_lane_c_out,
	output logic [9:0]       ref_dac_code_out,
	output logic             ref_range_3v_out,
	output logic             ref_enable_out
);
	adc_if_state_t r;
	adc_if_state_t n;

	logic [`PIN_W-1:0]  pins;
	logic [`PIN_W-1:0]  rise;
	logic [`PIN_W-1:0]  fall;
	logic               sw;
	logic               seq;
	logic               par;
	logic               ser;
	logic [2:0]         st_req;
	logic [2:0]         done;
	logic               load;
	logic               shift;
	logic [2:0]         en;
	logic [`LANE_W-1:0] la;
	logic [`LANE_W-1:0] lb;
	logic [`LANE_W-1:0] lc;

	function automatic logic [2:0] next_idx(input logic [2:0] idx);
		next_idx = (idx == `LAST_WORD) ? 3'h0 : idx + 3'h1;
	endfunction

	function automatic logic [15:0] to_twos(input logic [15:0] raw);
		to_twos = {~raw[15], raw[14:0]};
	endfunction

	function automatic logic [31:0] cw_merge(input logic [31:0] old, input logic [31:0] wr,
		input logic sw_mode, input logic ser_mode);
		if (!sw_mode)
			cw_merge = (old & ~`CW_HW_MASK) | (wr & `CW_HW_MASK);
		else if (!ser_mode || wr[`CW_FULL_UPD])
			cw_merge = wr;
		else
			cw_merge = {wr[31:`CW_TOP_LSB], old[`CW_TOP_LSB-1:0]};
	endfunction

	assign pins = {lane_enable_in, byte_order_select_in, word_byte_select_in, interface_select_in,
		config_source_select_in, chip_select_b_in, read_strobe_b_in, serial_data_in,
		serial_clk_in, frame_strobe_in, pair_sample_start_in};
	assign rise = r.s2 & ~r.s3;
	assign fall = ~r.s2 & r.s3;
	assign sw   = r.s2[`PIN_SRC];
	assign seq  = sw & r.cw[`CW_SEQ] & r.cw[`CW_EXTERNAL_CLOCK_SELECT]; // [RULE24]
	assign par  = ~r.s2[`PIN_IFACE];                     // [RULE14]
	assign ser  = r.s2[`PIN_IFACE];
	assign en   = r.s2[`PIN_EN_LSB +: 3];

	always_comb begin
		n = r;
		done = 3'h0;
		load = 1'b0;
		shift = 1'b0;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;

		// start routing by configuration source
		if (sw && !seq)
			st_req = {3{rise[`PIN_START_LSB]}}; // [RULE11]
		else
			st_req = rise[`PIN_START_LSB +: 3]; // [RULE11]

		for (int i = 0; i < 3; i++) begin
			if (r.busy_pair[i]) begin
				if (r.cnt[i] == 5'h01) begin
					done[i] = 1'b1;
					n.busy_pair[i] = 1'b0;
					n.res[2*i] = to_twos(r.hold[2*i]);     // [RULE22]
					n.res[2*i+1] = to_twos(r.hold[2*i+1]); // [RULE22]
				end else begin
					n.cnt[i] = r.cnt[i] - 5'h01;
				end
			end else if (st_req[i]) begin
				n.busy_pair[i] = 1'b1;
				n.cnt[i] = 5'(`CONV_CYCLES);                       // [RULE23]
				n.hold[2*i] = pair_first_input_in[16*i +: 16];    // [RULE23]
				n.hold[2*i+1] = pair_second_input_in[16*i +: 16]; // [RULE23]
			end
		end

		if (|st_req)
			n.busy_act = 1'b1; // [RULE1]
		else if (|done && n.busy_pair == 3'h0)
			n.busy_act = 1'b0; // [RULE2]
		n.seq_pulse = seq && |done && |n.busy_pair; // [RULE4]

		// a start that launches a pair wins over a completion in the same cycle
		if (|done && n.busy_pair == 3'h0)
			n.int_flag = 1'b1; // [RULE5]
		else if (|st_req)
			n.int_flag = 1'b0;
		if (|done && n.busy_pair == 3'h0) begin
			n.rd_idx = 3'h0;
			n.byte_ph = 1'b0;
		end

		// parallel read port
		n.db_oe_b = ~(par & ~r.s2[`PIN_CS] & ~r.s2[`PIN_RD]);
		if (par && !r.s2[`PIN_CS] && fall[`PIN_RD]) begin
			if (!r.s2[`PIN_WB]) begin
				n.db = r.res[r.rd_idx]; // [RULE14]
				n.rd_idx = next_idx(r.rd_idx);
			end else begin
				if (r.byte_ph ^ r.s2[`PIN_ORDER])
					n.db = {r.res[r.rd_idx][15:8], 8'h00}; // [RULE15]
				else
					n.db = {r.res[r.rd_idx][7:0], 8'h00};  // [RULE15]
				n.byte_ph = ~r.byte_ph;
				if (r.byte_ph)
					n.rd_idx = next_idx(r.rd_idx);
			end
		end

		// serial frame
		if (ser && fall[`PIN_FS]) begin
			load = 1'b1; // [RULE16]
			n.sdi_cnt = 6'h00;
		end
		if (ser && !r.s2[`PIN_FS] && rise[`PIN_SCLK])
			shift = 1'b1; // [RULE17]
		if (ser && !r.s2[`PIN_FS] && fall[`PIN_SCLK]) begin
			n.sdi_sr = {r.sdi_sr[30:0], r.s2[`PIN_SDI]}; // [RULE18]
			if (r.sdi_cnt != `CW_BITS)
				n.sdi_cnt = r.sdi_cnt + 6'h01;
		end
		if (ser && rise[`PIN_FS] && r.sdi_cnt == `CW_BITS)
			n.cw = cw_merge(r.cw, r.sdi_sr, sw, 1'b1); // [RULE12] [RULE13]
		if (cfg_write_in)
			n.cw = cw_merge(r.cw, cfg_word_in, sw, ser); // [RULE12] [RULE13]

		n.dac = n.cw[`CW_DAC_LSB +: `CW_DAC_W]; // [RULE8]
		n.range_3v = n.cw[`CW_REF_RANGE];        // [RULE7]
		n.ref_en = n.cw[`CW_REF_EN];             // [RULE10]
		n.busy_int = (n.cw[`CW_BUSY_IS_INT] ? n.int_flag : (n.busy_act & ~n.seq_pulse))
			^ n.cw[`CW_BUSY_POL]; // [RULE6]
	end

	// lane contents per number of enabled lanes
	always_comb begin
		la = '0;
		lb = '0;
		lc = '0;
		if (en[0] && en[1] && en[2]) begin
			la = {r.res[0], r.res[1], 64'h0}; // [RULE19]
			lb = {r.res[2], r.res[3], 64'h0}; // [RULE19]
			lc = {r.res[4], r.res[5], 64'h0}; // [RULE19]
		end else if (en[0] && en[1]) begin
			la = {r.res[0], r.res[1], r.res[4], 48'h0}; // [RULE20]
			lb = {r.res[2], r.res[3], r.res[5], 48'h0}; // [RULE20]
		end else if (en[0]) begin
			la = {r.res[0], r.res[1], r.res[2], r.res[3], r.res[4], r.res[5]}; // [RULE21]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			r <= '0;
			r.cw <= `CW_RESET_VAL;
			r.db_oe_b <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign busy_int_out = r.busy_int;
	assign parallel_data_bus_out = r.db;
	assign parallel_data_oe_b_out = r.db_oe_b;
	assign ref_dac_code_out = r.dac;
	assign ref_range_3v_out = r.range_3v;
	assign ref_enable_out = r.ref_en;

	// idle lanes load zeros and so stay low
	lane_shifter #(.W(`LANE_W)) u_lane_a (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.load_in    (load),
		.data_in    (la),
		.shift_in   (shift),
		.lane_out   (serial_out_lane_a_out)
	);
	lane_shifter #(.W(`LANE_W)) u_lane_b (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.load_in    (load),
		.data_in    (lb),
		.shift_in   (shift),
		.lane_out   (serial_out_lane_b_out)
	);
	lane_shifter #(.W(`LANE_W)) u_lane_c (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.load_in    (load),
		.data_in    (lc),
		.shift_in   (shift),
		.lane_out   (serial_out_lane_c_out) // [RULE25]
	);

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence pair_a_launch;
		st_req[0] && !r.busy_pair[0];
	endsequence

	sequence pair_a_converting;
		r.busy_pair[0] [*8];
	endsequence

	busy_rise_a: assert property (|st_req |=> r.busy_act) // [RULE1]
		else $error("busy not raised after start");

	busy_fall_a: assert property ($fell(r.busy_act) |-> $past(|done) && r.busy_pair == 3'h0) // [RULE2]
		else $error("busy fell with pairs still converting");

	seq_pulse_a: assert property (r.seq_pulse |-> r.busy_act && !busy_int_out != r.cw[`CW_BUSY_POL] // [RULE4]
		##1 !r.seq_pulse || $past(|done))
		else $error("sequential busy gap wrong");

	int_hold_a: assert property (r.int_flag && !(|st_req) |=> r.int_flag) // [RULE5]
		else $error("interrupt flag dropped without a new start");

	busy_pol_a: assert property (!r.cw[`CW_BUSY_IS_INT] && r.busy_act && !r.seq_pulse // [RULE6]
		|-> busy_int_out == !r.cw[`CW_BUSY_POL])
		else $error("busy output polarity wrong");

	ref_off_a: assert property ($past(!rst_b_in) |-> !ref_enable_out && ref_dac_code_out == 10'h000) // [RULE10]
		else $error("reference not powered down after reset");

	start_route_a: assert property (sw && !seq && rise[`PIN_START_LSB] && r.busy_pair == 3'h0 // [RULE11]
		|=> r.busy_pair == 3'h7)
		else $error("pair A start did not start all pairs");

	conv_len_a: assert property (pair_a_launch |=> pair_a_converting) // [RULE23]
		else $error("pair A conversion ended early");

	twos_code_a: assert property (done[0] |=> r.res[0] == to_twos($past(r.hold[0]))) // [RULE22]
		else $error("result not two's complement");

	lane_idle_a: assert property (load && !en[2] |=> !serial_out_lane_c_out) // [RULE25]
		else $error("disabled lane carries data");

endmodule

/* design/adc_if_consts.svh */
`ifndef ADC_IF_CONSTS_SVH
`define ADC_IF_CONSTS_SVH

// control word field positions
`define CW_DAC_LSB       0
`define CW_DAC_W         10
`define CW_EXTERNAL_CLOCK_SELECT        11
`define CW_FULL_UPD      16
`define CW_REF_RANGE     18
`define CW_REF_EN        19
`define CW_BUSY_POL      20
`define CW_BUSY_IS_INT   21
`define CW_SEQ           23
`define CW_TOP_LSB       24
`define CW_RESET_VAL     32'h0000_0000
// bits C[22:18], C[15:13] and C[9:0]
`define CW_HW_MASK       32'h007C_E3FF
`define CW_BITS          6'h20

// conversion length in half conversion clock cycles, rounded up to whole cycles
`define CONV_HALF_CYCLES 37
`define CONV_CYCLES      ((`CONV_HALF_CYCLES + 1) / 2)

// positions inside the synchronised pin vector
`define PIN_START_LSB    0
`define PIN_FS           3
`define PIN_SCLK         4
`define PIN_SDI          5
`define PIN_RD           6
`define PIN_CS           7
`define PIN_SRC          8
`define PIN_IFACE        9
`define PIN_WB           10
`define PIN_ORDER        11
`define PIN_EN_LSB       12
`define PIN_W            15

`define LAST_WORD        3'h5
`define LANE_W           96

`endif

/* design/adc_if_pkg.sv */
package adc_if_pkg;
`include "adc_if_consts.svh"

	typedef struct packed {
		logic [`PIN_W-1:0] s1;
		logic [`PIN_W-1:0] s2;
		logic [`PIN_W-1:0] s3;
		logic [31:0]       cw;
		logic [2:0]        busy_pair;
		logic [2:0][4:0]   cnt;
		logic [5:0][15:0]  hold;
		logic [5:0][15:0]  res;
		logic              busy_act;
		logic              seq_pulse;
		logic              int_flag;
		logic              busy_int;
		logic [2:0]        rd_idx;
		logic              byte_ph;
		logic [15:0]       db;
		logic              db_oe_b;
		logic [31:0]       sdi_sr;
		logic [5:0]        sdi_cnt;
		logic [9:0]        dac;
		logic              range_3v;
		logic              ref_en;
	} adc_if_state_t;

endpackage

/* design/lane_shifter.sv */
`timescale 1ns/1ps
module lane_shifter #(
	parameter int W = 96
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_b_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] data_in,
	input  wire logic         shift_in,
	output logic              lane_out
);
	logic [W-1:0] sr_r;

	// first bit appears at load, each later bit on a shift request
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			sr_r     <= '0;
			lane_out <= 1'b0;
		end else if (load_in) begin
			sr_r     <= {data_in[W-2:0], 1'b0};
			lane_out <= data_in[W-1];
		end else if (shift_in) begin
			sr_r     <= {sr_r[W-2:0], 1'b0};
			lane_out <= sr_r[W-1];
		end
	end
endmodule

/* dv/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
	output logic      frame_strobe_out,
	output logic      serial_clk_out,
	output logic      serial_data_out,
	input  wire logic lane_a_in,
	input  wire logic lane_b_in,
	input  wire logic lane_c_in
);
	logic [95:0] qa;
	logic [95:0] qb;
	logic [95:0] qc;

	initial begin
		frame_strobe_out = 1'b1;
		serial_clk_out = 1'b1;
		serial_data_out = 1'b0;
	end

	// clock stands high between frames; long high phase leaves the lanes time to settle
	task automatic xfer(input logic [31:0] cw, input int nbits);
		frame_strobe_out = 1'b0;
		serial_data_out = cw[31];
		#330;
		for (int i = 0; i < nbits; i++) begin
			serial_clk_out = 1'b0;
			qa = {qa[94:0], lane_a_in};
			qb = {qb[94:0], lane_b_in};
			qc = {qc[94:0], lane_c_in};
			#120;
			serial_clk_out = 1'b1;
			serial_data_out = (i < 31) ? cw[30-i] : 1'b0;
			#200;
		end
		frame_strobe_out = 1'b1;
		#400;
	endtask
endmodule

/* dv/test_adc_host_if.sv */
`timescale 1ns/1ps
`include "adc_if_consts.svh"
module test_adc_host_if;
	import adc_if_pkg::*;
	typedef struct packed {
		logic [15:0] smp;
		logic [15:0] code;
	} row_t;
	logic        clk, rst_b, src, ifs, wb, ord, cs_b, rd_b, cfg_wr;
	logic [2:0]  start, en;
	logic [47:0] first, second;
	logic [31:0] cfg;
	logic        busy, oe_b, la, lb, lc, fs, sck, sdi, r3v, ren;
	logic [15:0] db;
	logic [9:0]  dac;
	int          bad_count, tests_run, n;
	row_t        rows [4] = '{'{16'hFFFF, 16'h7FFF}, '{16'h0000, 16'h8000}, '{16'h7FFF, 16'hFFFF}, '{16'h8000, 16'h0000}};

	adc_host_if dut_u (
		.sys_clk_in(clk), .rst_b_in(rst_b), .pair_sample_start_in(start), .config_source_select_in(src),
		.interface_select_in(ifs), .word_byte_select_in(wb), .byte_order_select_in(ord),
		.chip_select_b_in(cs_b), .read_strobe_b_in(rd_b), .frame_strobe_in(fs), .serial_clk_in(sck),
		.serial_data_in(sdi), .lane_enable_in(en), .pair_first_input_in(first), .pair_second_input_in(second),
		.cfg_write_in(cfg_wr), .cfg_word_in(cfg), .busy_int_out(busy), .parallel_data_bus_out(db),
		.parallel_data_oe_b_out(oe_b), .serial_out_lane_a_out(la), .serial_out_lane_b_out(lb),
		.serial_out_lane_c_out(lc), .ref_dac_code_out(dac), .ref_range_3v_out(r3v), .ref_enable_out(ren)
	);
	serial_host_model host_u (
		.frame_strobe_out(fs), .serial_clk_out(sck), .serial_data_out(sdi),
		.lane_a_in(la), .lane_b_in(lb), .lane_c_in(lc)
	);

	task automatic chk(input logic [95:0] seen, input logic [95:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// n counts the cycles spent waiting
	task automatic wait_busy(input logic lvl);
		n = 0;
		while (busy !== lvl) begin
			cyc(1);
			n++;
			if (n > 200) begin
				bad_count++;
				final_report();
			end
		end
	endtask
	task automatic conv(input logic [2:0] s);
		@(posedge clk) start <= s;
		wait_busy(1'b1);
		wait_busy(1'b0);
		start <= 3'h0;
	endtask
	task automatic rd(input logic [15:0] want);
		@(posedge clk) begin
			cs_b <= 1'b0;
			rd_b <= 1'b0;
		end
		cyc(5);
		chk({oe_b, db}, {1'b0, want});
		@(posedge clk) begin
			cs_b <= 1'b1;
			rd_b <= 1'b1;
		end
		cyc(3);
	endtask
	task automatic cfgw(input logic [31:0] w);
		@(posedge clk) begin
			cfg_wr <= 1'b1;
			cfg <= w;
		end
		@(posedge clk) cfg_wr <= 1'b0;
		cyc(2);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		{rst_b, src, ifs, wb, ord, cfg_wr, start, en, first, second, cfg} = '0;
		{cs_b, rd_b} = 2'b11;
		cyc(12);
		@(posedge clk) rst_b <= 1'b1;
		cyc(4);
		chk({busy, oe_b, ren, dac}, {1'b0, 1'b1, 1'b0, 10'h000});
		$display("reset test done");
		foreach (rows[r]) begin
			for (int k = 0; k < 3; k++) begin
				first[16*k+:16] <= rows[r].smp ^ 16'(2*k);
				second[16*k+:16] <= rows[r].smp ^ 16'(2*k+1);
			end
			conv(3'h7);
			chk(n, `CONV_CYCLES);
			for (int k = 0; k < 6; k++) rd(rows[r].code ^ 16'(k));
			$display("row %0d done", r);
		end
		first <= {3{16'hB4A5}};
		second <= {3{16'h0F1E}};
		wb <= 1'b1;
		conv(3'h7);
		rd(16'hA500);
		rd(16'h3400);
		ord <= 1'b1;
		rd(16'h8F00);
		rd(16'h1E00);
		{wb, ord} <= 2'b00;
		$display("byte test done");
		cfgw(32'h0094_03FF);
		chk({busy, r3v, ren, dac}, {1'b1, 1'b1, 1'b0, 10'h3FF});
		cfgw(32'h0);
		chk({busy, r3v}, 2'b00);
		$display("config test done");
		src <= 1'b1;
		first <= '0;
		second <= '0;
		@(posedge clk) start <= 3'h6;
		cyc(10);
		chk(busy, 1'b0);
		start <= 3'h0;
		cyc(2);
		conv(3'h1);
		for (int k = 0; k < 6; k++) rd(16'h8000);
		cfgw(32'h0020_0000);
		@(posedge clk) start <= 3'h1;
		wait_busy(1'b0);
		wait_busy(1'b1);
		rd(16'h8000);
		chk(busy, 1'b1);
		start <= 3'h0;
		cfgw(32'h0080_0800);
		@(posedge clk) start <= 3'h1;
		cyc(6);
		start <= 3'h3;
		wait_busy(1'b0);
		cyc(1);
		chk(busy, 1'b1);
		wait_busy(1'b0);
		start <= 3'h0;
		$display("start mode tests done");
		src <= 1'b0;
		cfgw(32'h0);
		ifs <= 1'b1;
		first <= 48'h9C0C_9B0B_9A0A;
		second <= 48'h1C1C_1B1B_1A1A;
		conv(3'h7);
		en <= 3'h1;
		cyc(4);
		host_u.xfer(32'h0, 96);
		chk(host_u.qa, 96'h1A0A_9A1A_1B0B_9B1B_1C0C_9C1C);
		chk(host_u.qb | host_u.qc, 96'h0);
		en <= 3'h3;
		cyc(4);
		host_u.xfer(32'h0, 48);
		chk({host_u.qa[47:0], host_u.qb[47:0]}, 96'h1A0A_9A1A_1C0C_1B0B_9B1B_9C1C);
		en <= 3'h7;
		cyc(4);
		host_u.xfer(32'hFF04_0155, 32);
		chk({host_u.qa[31:0], host_u.qb[31:0], host_u.qc[31:0]}, 96'h1A0A9A1A_1B0B9B1B_1C0C9C1C);
		cyc(4);
		chk({r3v, dac}, {1'b1, 10'h155});
		$display("serial test done");
		final_report();
	end
endmodule
